// file: logic/status_bank_params.svh
// constants for the output status and flag register bank
// Function
// - level field sets line gain 0..9 dB
// - bit 3 unmutes line output, resets muted
// - bit 1 shows gain still pending, resets 1
// - line output power at level D0, power D3
// - dac power left D7, right D6
// - mono line D5, left line D4 power
// - headphone power left D2, right D1
// - live short status in bits 7..4
// - common driver power in bits 3, 2
// - sticky short flags in bits 7..4
// - sticky button press flag bit 3
// - sticky headset insert or remove bit 2
// - sticky noise gate flags bits 1, 0
`ifndef STATUS_BANK_PARAMS_SVH
`define STATUS_BANK_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_LINE_LEVEL    10'h05D
`define IDX_POWER_STATUS  10'h05E
`define IDX_SHORT_STATUS  10'h05F
`define IDX_EVENT_FLAGS   10'h060
`define IDX_IRQ_ENABLE    10'h061
`define IDX_IRQ_CLEAR     10'h062

// field positions of the level register
`define LVL_GAIN_MSB      7
`define LVL_GAIN_LSB      4
`define LVL_UNMUTE_BIT    3

// reset values
`define RST_GAIN          4'h0
`define RST_UNMUTE        1'b0
`define RST_PENDING       1'b1
`define RST_FLAGS         8'h00
`define RST_IRQ_EN        8'h00

// highest legal gain code, 9 dB
`define GAIN_MAX_CODE     4'h9

// gain settling: one 1 dB step per GAIN_STEP_NS
`define CLK_PERIOD_NS     5
`define GAIN_STEP_NS      1000
`define GAIN_STEP_CYC     ((`GAIN_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAIN_CNT_W        8

// axi response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// file: logic/status_bank_pkg.sv
// types shared by the status and flag register bank
package status_bank_pkg;

  // levels coming from the analog drivers and detectors
  typedef struct packed {
    logic       dac_left_up;
    logic       dac_right_up;
    logic       mono_line_output_up;
    logic       left_line_output_up;
    logic       right_line_output_up;
    logic       left_headphone_driver_up;
    logic       right_headphone_driver_up;
    logic       left_common_driver_up;
    logic       right_common_driver_up;
    logic [3:0] short_live;       // hp left, hp right, com left, com right
    logic       button_pressed;
    logic       headset_present;
    logic       noise_gate_left;
    logic       noise_gate_right;
  } analog_status_s;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_LEVEL, SEL_POWER, SEL_SHORT, SEL_FLAGS, SEL_IRQ_EN, SEL_IRQ_CLR, SEL_NONE
  } reg_sel_e;

  // state of the gain settling ramp
  typedef struct packed {
    logic [3:0]  applied;
    logic [7:0]  count;
    logic        pending;
  } ramp_state_s;

endpackage

// file: logic/sync_2ff.sv
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 17
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  // first stage feeds only the second stage
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_s;

  sync_state_s state;
  sync_state_s next_state;

  // shift one stage per clock
  always_comb begin
    next_state.meta   = async_i;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.stable;
endmodule // sync_2ff

// file: logic/gain_ramp.sv
// steps the applied line output gain toward the programmed code
`timescale 1ns/1ps
`include "status_bank_params.svh"
module gain_ramp #(
  parameter int STEP_CYC = `GAIN_STEP_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic [3:0] target_i,
  output logic      [3:0] applied_o,
  output logic            pending_o
);
  status_bank_pkg::ramp_state_s state;
  status_bank_pkg::ramp_state_s next_state;
  logic [3:0] goal;

  // reserved codes can be written to the level field; saturate at 9 so the driver stays in range
  assign goal = (target_i > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : target_i;

  // one 1 dB step per interval avoids zipper noise on large changes
  always_comb begin
    next_state = state;
    if (state.applied == goal) begin
      next_state.count = '0;
    end else if (state.count == 8'(STEP_CYC - 1)) begin
      next_state.count = '0;
      if (state.applied < goal) begin
        next_state.applied = state.applied + 4'h1;
      end else begin
        next_state.applied = state.applied - 4'h1;
      end
    end else begin
      next_state.count = state.count + 8'h01;
    end
    next_state.pending = (next_state.applied != goal);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state.applied <= `RST_GAIN;
      state.count   <= '0;
      state.pending <= `RST_PENDING;
    end else begin
      state <= next_state;
    end
  end

  assign applied_o = state.applied;
  assign pending_o = state.pending;
endmodule // gain_ramp

// file: logic/output_status_flag_bank.sv
// axi4-lite register bank for line output control, power, short and event flags
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "status_bank_params.svh"
module output_status_flag_bank #(
  parameter int ADDR_W   = 12,
  parameter int STEP_CYC = `GAIN_STEP_CYC
) (
  input  wire logic                            clk_sys_i,
  input  wire logic                            reset_i,
  // write address channel
  input  wire logic [ADDR_W-1:0]               s_axi_awaddr_i,
  input  wire logic                            s_axi_awvalid_i,
  output logic                                 s_axi_awready_o,
  // write data channel
  input  wire logic [31:0]                     s_axi_wdata_i,
  input  wire logic [3:0]                      s_axi_wstrb_i,
  input  wire logic                            s_axi_wvalid_i,
  output logic                                 s_axi_wready_o,
  // write response channel
  output logic [1:0]                           s_axi_bresp_o,
  output logic                                 s_axi_bvalid_o,
  input  wire logic                            s_axi_bready_i,
  // read address channel
  input  wire logic [ADDR_W-1:0]               s_axi_araddr_i,
  input  wire logic                            s_axi_arvalid_i,
  output logic                                 s_axi_arready_o,
  // read data channel
  output logic [31:0]                          s_axi_rdata_o,
  output logic [1:0]                           s_axi_rresp_o,
  output logic                                 s_axi_rvalid_o,
  input  wire logic                            s_axi_rready_i,
  // asynchronous levels from the analog section
  input  wire status_bank_pkg::analog_status_s analog_status_i,
  // line output drive controls
  output logic [3:0]                           right_line_output_gain_o,
  output logic                                 right_line_output_unmute_o,
  // level interrupt
  output logic                                 irq_o
);

  // whole register state of the bank
  typedef struct packed {
    logic              aw_held;    // write address taken, waiting for data
    logic [ADDR_W-1:0] aw_addr;
    logic              w_held;     // write data taken, waiting for address
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [3:0]        gain_code;  // programmed level field
    logic              unmute;
    logic [7:0]        irq_en;
    logic [7:0]        flags;      // sticky event flags
    logic              button_prev;
    logic              headset_prev;
  } bank_state_s;

  bank_state_s state;
  bank_state_s next_state;

  status_bank_pkg::analog_status_s live;  // synchronised analog levels
  logic [3:0]                      gain_applied;
  logic                            gain_pending;

  // handshake and decode helpers
  logic                            aw_take;
  logic                            w_take;
  logic                            ar_take;
  logic                            do_write;
  logic [ADDR_W-1:0]               wr_addr;
  logic [7:0]                      wr_data;
  logic                            wr_lane0;
  status_bank_pkg::reg_sel_e       wr_sel;
  status_bank_pkg::reg_sel_e       rd_sel;
  logic [7:0]                      rd_value;
  logic [7:0]                      flag_set;
  logic [7:0]                      flag_clr;

  // every analog level is asynchronous to the core clock
  sync_2ff #(
    .WIDTH ($bits(status_bank_pkg::analog_status_s))
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   (analog_status_i),
    .sync_o    (live)
  );

  // gain settles in 1 dB steps; pending shows until it matches the code, capped at 9
  gain_ramp #(
    .STEP_CYC (STEP_CYC)
  ) u_ramp (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .target_i  (state.gain_code),
    .applied_o (gain_applied),
    .pending_o (gain_pending)
  );

  // map a byte address to a register; low two bits ignored
  function automatic status_bank_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    case (idx)
      `IDX_LINE_LEVEL:   decode = status_bank_pkg::SEL_LEVEL;
      `IDX_POWER_STATUS: decode = status_bank_pkg::SEL_POWER;
      `IDX_SHORT_STATUS: decode = status_bank_pkg::SEL_SHORT;
      `IDX_EVENT_FLAGS:  decode = status_bank_pkg::SEL_FLAGS;
      `IDX_IRQ_ENABLE:   decode = status_bank_pkg::SEL_IRQ_EN;
      `IDX_IRQ_CLEAR:    decode = status_bank_pkg::SEL_IRQ_CLR;
      default:           decode = status_bank_pkg::SEL_NONE;
    endcase
  endfunction

  // channel handshakes; one write and one read outstanding at most
  assign s_axi_awready_o = !state.aw_held && !state.bvalid;
  assign s_axi_wready_o  = !state.w_held && !state.bvalid;
  assign s_axi_arready_o = !state.rvalid;
  assign aw_take         = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take          = s_axi_wvalid_i && s_axi_wready_o;
  assign ar_take         = s_axi_arvalid_i && s_axi_arready_o;

  // address and data may arrive in either order; write once both are in
  assign do_write = (aw_take || state.aw_held) && (w_take || state.w_held);
  assign wr_addr  = state.aw_held ? state.aw_addr : s_axi_awaddr_i;
  assign wr_data  = state.w_held ? state.w_data : s_axi_wdata_i[7:0];
  assign wr_lane0 = state.w_held ? state.w_lane0 : s_axi_wstrb_i[0];
  assign wr_sel   = decode(wr_addr);
  assign rd_sel   = decode(s_axi_araddr_i);

  // read value of the addressed register; reserved bits read zero
  always_comb begin
    rd_value = 8'h00;
    case (rd_sel)
      status_bank_pkg::SEL_LEVEL: begin
        rd_value[`LVL_GAIN_MSB:`LVL_GAIN_LSB] = state.gain_code;
        rd_value[`LVL_UNMUTE_BIT]             = state.unmute;
        rd_value[2]                           = 1'b0;
        rd_value[1]                           = gain_pending;
        rd_value[0]                           = live.right_line_output_up;
      end
      status_bank_pkg::SEL_POWER: begin
        rd_value[7] = live.dac_left_up;
        rd_value[6] = live.dac_right_up;
        rd_value[5] = live.mono_line_output_up;
        rd_value[4] = live.left_line_output_up;
        rd_value[3] = live.right_line_output_up;
        rd_value[2] = live.left_headphone_driver_up;
        rd_value[1] = live.right_headphone_driver_up;
        rd_value[0] = 1'b0;
      end
      status_bank_pkg::SEL_SHORT: begin
        rd_value[7:4] = live.short_live;
        rd_value[3]   = live.left_common_driver_up;
        rd_value[2]   = live.right_common_driver_up;
        rd_value[1:0] = 2'h0;
      end
      status_bank_pkg::SEL_FLAGS: begin
        rd_value = state.flags;
      end
      status_bank_pkg::SEL_IRQ_EN: begin
        rd_value = state.irq_en;
      end
      // the clear register is write-only and reads zero
      status_bank_pkg::SEL_IRQ_CLR: begin
        rd_value = 8'h00;
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  // events that set sticky flags this cycle
  always_comb begin
    flag_set[7:4] = live.short_live;
    flag_set[3]   = live.button_pressed && !state.button_prev;
    flag_set[2]   = live.headset_present != state.headset_prev;
    flag_set[1]   = live.noise_gate_left;
    flag_set[0]   = live.noise_gate_right;
  end

  // flags clear on a read of the flag register or through the clear register
  always_comb begin
    flag_clr = 8'h00;
    if (ar_take && rd_sel == status_bank_pkg::SEL_FLAGS) begin
      flag_clr = 8'hFF;
    end
    if (do_write && wr_lane0 && wr_sel == status_bank_pkg::SEL_IRQ_CLR) begin
      flag_clr = flag_clr | wr_data;
    end
  end

  // next state of the whole bank
  always_comb begin
    next_state = state;

    // edge trackers for button and headset detectors
    next_state.button_prev  = live.button_pressed;
    next_state.headset_prev = live.headset_present;

    // set wins over clear, so an event in the clearing cycle survives
    next_state.flags = (state.flags & ~flag_clr) | flag_set;

    // hold a lone write address or data beat until its partner arrives
    if (aw_take && !do_write) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr_i;
    end
    if (w_take && !do_write) begin
      next_state.w_held  = 1'b1;
      next_state.w_data  = s_axi_wdata_i[7:0];
      next_state.w_lane0 = s_axi_wstrb_i[0];
    end

    // perform the write and raise the response
    if (do_write) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = `RESP_OKAY;
      case (wr_sel)
        status_bank_pkg::SEL_LEVEL: begin
          // only gain and mute are writable; status bits keep tracking hardware
          if (wr_lane0) begin
            next_state.gain_code = wr_data[`LVL_GAIN_MSB:`LVL_GAIN_LSB];
            next_state.unmute    = wr_data[`LVL_UNMUTE_BIT];
          end
        end
        status_bank_pkg::SEL_IRQ_EN: begin
          if (wr_lane0) begin
            next_state.irq_en = wr_data;
          end
        end
        // clear handled with the flags above
        status_bank_pkg::SEL_IRQ_CLR: begin
          next_state.bresp = `RESP_OKAY;
        end
        // read-only registers accept the write and ignore it
        status_bank_pkg::SEL_POWER,
        status_bank_pkg::SEL_SHORT,
        status_bank_pkg::SEL_FLAGS: begin
          next_state.bresp = `RESP_OKAY;
        end
        default: begin
          next_state.bresp = `RESP_SLVERR;
        end
      endcase
    end else if (state.bvalid && s_axi_bready_i) begin
      next_state.bvalid = 1'b0;
    end

    // read data is registered one cycle after the address is taken
    if (ar_take) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = rd_value;
      if (rd_sel == status_bank_pkg::SEL_NONE) begin
        next_state.rresp = `RESP_SLVERR;
      end else begin
        next_state.rresp = `RESP_OKAY;
      end
    end else if (state.rvalid && s_axi_rready_i) begin
      next_state.rvalid = 1'b0;
    end
  end

  // register the bank; reset leaves the output muted at 0 dB
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state              <= '0;
      state.gain_code    <= `RST_GAIN;
      state.unmute       <= `RST_UNMUTE;
      state.irq_en       <= `RST_IRQ_EN;
      state.flags        <= `RST_FLAGS;
      state.bresp        <= `RESP_OKAY;
      state.rresp        <= `RESP_OKAY;
    end else begin
      state <= next_state;
    end
  end

  // bus outputs straight from the state register
  assign s_axi_bvalid_o = state.bvalid;
  assign s_axi_bresp_o  = state.bresp;
  assign s_axi_rvalid_o = state.rvalid;
  assign s_axi_rresp_o  = state.rresp;
  assign s_axi_rdata_o  = {24'h000000, state.rdata};

  // drive controls: applied gain follows the ramp, mute is direct
  assign right_line_output_gain_o   = gain_applied;
  assign right_line_output_unmute_o = state.unmute;

  // level interrupt while any enabled flag is set
  assign irq_o = |(state.flags & state.irq_en);

endmodule // output_status_flag_bank

// file: testbench/status_bank_checker.sv
// port-level assertions for the status and flag register bank
`timescale 1ns/1ps
`include "status_bank_params.svh"
module status_bank_checker #(
  parameter int ADDR_W   = 12,
  parameter int STEP_CYC = 4
) (
  input wire logic                            clk_sys_i,
  input wire logic                            reset_i,
  input wire logic [ADDR_W-1:0]               s_axi_awaddr_i,
  input wire logic                            s_axi_awvalid_i,
  input wire logic                            s_axi_awready_o,
  input wire logic [31:0]                     s_axi_wdata_i,
  input wire logic [3:0]                      s_axi_wstrb_i,
  input wire logic                            s_axi_wvalid_i,
  input wire logic                            s_axi_wready_o,
  input wire logic [1:0]                      s_axi_bresp_o,
  input wire logic                            s_axi_bvalid_o,
  input wire logic                            s_axi_bready_i,
  input wire logic [ADDR_W-1:0]               s_axi_araddr_i,
  input wire logic                            s_axi_arvalid_i,
  input wire logic                            s_axi_arready_o,
  input wire logic [31:0]                     s_axi_rdata_o,
  input wire logic [1:0]                      s_axi_rresp_o,
  input wire logic                            s_axi_rvalid_o,
  input wire logic                            s_axi_rready_i,
  input wire status_bank_pkg::analog_status_s analog_status_i,
  input wire logic [3:0]                      right_line_output_gain_o,
  input wire logic                            right_line_output_unmute_o,
  input wire logic                            irq_o
);
  logic [ADDR_W-1:0] rd_addr; // address of the read in flight
  // keep the read address so returned data is judged per register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rd_addr <= '0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_addr <= s_axi_araddr_i;
    end
  end
  wire logic is_lvl = rd_addr[ADDR_W-1:2] == `IDX_LINE_LEVEL;   // level register read
  wire logic is_pwr = rd_addr[ADDR_W-1:2] == `IDX_POWER_STATUS; // power register read
  wire logic is_sht = rd_addr[ADDR_W-1:2] == `IDX_SHORT_STATUS; // short register read
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_b_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_answer;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read not answered");
  property p_gain_max;
    right_line_output_gain_o <= `GAIN_MAX_CODE;
  endproperty
  a_gain_max: assert property (p_gain_max) else $error("gain above 9 dB");
  property p_gain_step;
    !$stable(right_line_output_gain_o) |-> right_line_output_gain_o ==
      $past(right_line_output_gain_o) + 4'h1 ||
      right_line_output_gain_o == $past(right_line_output_gain_o) - 4'h1;
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gain jumped");
  property p_mute_write;
    !$stable(right_line_output_unmute_o) |-> $rose(s_axi_bvalid_o);
  endproperty
  a_mute_write: assert property (p_mute_write) else $error("mute moved without write");
  property p_lvl_mute;
    s_axi_rvalid_o && is_lvl |->
      s_axi_rdata_o[3] == right_line_output_unmute_o && !s_axi_rdata_o[2];
  endproperty
  a_lvl_mute: assert property (p_lvl_mute) else $error("mute readback wrong");
  property p_lvl_gain;
    s_axi_rvalid_o && is_lvl && !s_axi_rdata_o[1] |->
      s_axi_rdata_o[7:4] == right_line_output_gain_o;
  endproperty
  a_lvl_gain: assert property (p_lvl_gain) else $error("settled gain mismatch");
  property p_rsv_zero;
    s_axi_rvalid_o |-> !(is_pwr && s_axi_rdata_o[0]) && !(is_sht && |s_axi_rdata_o[1:0]);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
  property p_upper_zero;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  c_pending: cover property (s_axi_rvalid_o && is_lvl && s_axi_rdata_o[1]);
  c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == `RESP_SLVERR);
  c_irq: cover property ($rose(irq_o));
endmodule // status_bank_checker

bind output_status_flag_bank status_bank_checker #(.ADDR_W(ADDR_W), .STEP_CYC(STEP_CYC))
  u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wstrb_i(s_axi_wstrb_i),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .analog_status_i(analog_status_i), .right_line_output_gain_o(right_line_output_gain_o),
  .right_line_output_unmute_o(right_line_output_unmute_o), .irq_o(irq_o));

// file: testbench/tb_top.sv
// self-checking bench for the status and flag register bank
`timescale 1ns/1ps
`include "status_bank_params.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  localparam int          STEP  = 4;                             // shortened gain step
  localparam logic [11:0] A_LVL = 12'(`IDX_LINE_LEVEL) << 2;     // level register
  localparam logic [11:0] A_PWR = 12'(`IDX_POWER_STATUS) << 2;   // power status
  localparam logic [11:0] A_SHT = 12'(`IDX_SHORT_STATUS) << 2;   // short status
  localparam logic [11:0] A_FLG = 12'(`IDX_EVENT_FLAGS) << 2;    // sticky flags
  localparam logic [11:0] A_IEN = 12'(`IDX_IRQ_ENABLE) << 2;     // interrupt enable
  localparam logic [11:0] A_ICL = 12'(`IDX_IRQ_CLEAR) << 2;      // interrupt clear
  logic                           clk_sys, reset, awvalid, wvalid, bready, arvalid, rready;
  logic                           awready, wready, bvalid, arready, rvalid, unmute, irq;
  logic [11:0]                    awaddr, araddr;
  logic [31:0]                    wdata, rdata;
  logic [3:0]                     wstrb, gain;
  logic [1:0]                     bresp, rresp;
  status_bank_pkg::analog_status_s ana;                           // analog levels
  int                             miscompares, cmp_count, n;
  logic [7:0] pw [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00, 8'h00};
  logic [7:0] sh [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h04};
  logic [11:0] ro [3] = '{A_PWR, A_SHT, A_FLG};                   // read-only registers

  output_status_flag_bank #(.ADDR_W(12), .STEP_CYC(STEP)) u_dut (
    .clk_sys_i(clk_sys), .reset_i(reset), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .analog_status_i(ana), .right_line_output_gain_o(gain),
    .right_line_output_unmute_o(unmute), .irq_o(irq));

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // verdict and end of run, shared with the watchdog
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // write: address and data together, each dropped when taken; bready late
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int k = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (k == 2) bready <= 1'b1;
    end while (!(bvalid && bready) && k < 50);
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // read: rready late, data taken at the handshake edge
  task automatic rd(input logic [11:0] a, input logic [7:0] ex, input logic [1:0] er);
    int k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (arready) arvalid <= 1'b0;
      if (k == 2) rready <= 1'b1;
    end while (!(rvalid && rready) && k < 50);
    `CHK($sformatf("read %h", a), {24'h000000, ex}, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // analog levels change, then wait out synchroniser and flag logic
  task automatic set_ana(input logic [16:0] v);
    ana <= v;
    repeat (5) @(posedge clk_sys);
  endtask

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end

  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, ana} = '0;
    wstrb = 4'hF;
    miscompares = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    // reset values, then an unmapped address both ways
    rd(A_LVL, 8'h00, `RESP_OKAY);
    foreach (ro[i]) rd(ro[i], 8'h00, `RESP_OKAY);
    rd(12'h000, 8'h00, `RESP_SLVERR);
    wr(12'h000, 8'h55, `RESP_SLVERR);
    // each power input alone, so a swapped bit shows up
    for (int i = 0; i < 9; i++) begin
      set_ana(17'h10000 >> i);
      rd(A_PWR, pw[i], `RESP_OKAY);
      rd(A_SHT, sh[i], `RESP_OKAY);
      rd(A_LVL, {7'h00, i == 4}, `RESP_OKAY);
    end
    // live shorts, then the sticky copy after the short has gone
    for (int j = 0; j < 4; j++) begin
      set_ana(17'h00080 >> j);
      rd(A_SHT, 8'h80 >> j, `RESP_OKAY);
      set_ana(17'h00000);
      rd(A_FLG, 8'h80 >> j, `RESP_OKAY);
      rd(A_FLG, 8'h00, `RESP_OKAY);
    end
    // noise gates: a level still present survives the clearing read
    set_ana(17'h00002);
    rd(A_FLG, 8'h02, `RESP_OKAY);
    rd(A_FLG, 8'h02, `RESP_OKAY);
    set_ana(17'h00001);
    rd(A_FLG, 8'h03, `RESP_OKAY);
    set_ana(17'h00000);
    rd(A_FLG, 8'h01, `RESP_OKAY);
    rd(A_FLG, 8'h00, `RESP_OKAY);
    // button and headset events through the interrupt
    wr(A_IEN, 8'h0C, `RESP_OKAY);
    rd(A_IEN, 8'h0C, `RESP_OKAY);
    set_ana(17'h00008);
    `CHK("irq", 1'b1, irq)
    rd(A_FLG, 8'h08, `RESP_OKAY);
    rd(A_FLG, 8'h00, `RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    set_ana(17'h00004);
    `CHK("irq", 1'b1, irq)
    wr(A_ICL, 8'h04, `RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    rd(A_FLG, 8'h00, `RESP_OKAY);
    set_ana(17'h00000);
    wr(A_IEN, 8'h00, `RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    rd(A_FLG, 8'h04, `RESP_OKAY);
    // gain ramps to 9 dB while the pending bit stands
    wr(A_LVL, 8'h98, `RESP_OKAY);
    rd(A_LVL, 8'h9A, `RESP_OKAY);
    n = 0;
    while (gain !== 4'h9 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("settle", 1'b1, (n >= 7 * STEP && n <= 9 * STEP + 2))
    `CHK("gain", 4'h9, gain)
    `CHK("unmute", 1'b1, unmute)
    rd(A_LVL, 8'h98, `RESP_OKAY);
    wr(A_LVL, 8'h9B, `RESP_OKAY);
    rd(A_LVL, 8'h98, `RESP_OKAY);
    foreach (ro[i]) begin
      wr(ro[i], 8'hFC, `RESP_OKAY);
      rd(ro[i], 8'h00, `RESP_OKAY);
    end
    // back to 0 dB and muted
    wr(A_LVL, 8'h00, `RESP_OKAY);
    `CHK("unmute", 1'b0, unmute)
    n = 0;
    while (gain !== 4'h0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("gain", 4'h0, gain)
    test_done();
  end
endmodule // tb_top
